// file: vsb_params.svh
// constants for the virtual serial handshake bridge
`ifndef VSB_PARAMS_SVH
`define VSB_PARAMS_SVH
`define VSB_CLK_HZ 50000000
`define VSB_BAUD_DEF 115200
`define VSB_BAUD_MIN 9600
`define VSB_BAUD_MAX 921600
`define VSB_DIV_DEF (`VSB_CLK_HZ / `VSB_BAUD_DEF)
`define VSB_DIV_MIN (`VSB_CLK_HZ / `VSB_BAUD_MAX)
`define VSB_DIV_MAX (`VSB_CLK_HZ / `VSB_BAUD_MIN)
`define VSB_DIV_W 13
`define VSB_DATA_BITS 8
`define VSB_FIFO_DEPTH 32
`define VSB_HS_OUT_BIT 0
`define VSB_HS_IN_BIT 1
`endif

// file: vsb_pkg.sv
// types for the virtual serial handshake bridge
`include "vsb_params.svh"
package vsb_pkg;
  typedef enum logic [1:0] {
    VSB_HS_DISABLED = 2'b00,
    VSB_HS_OUT      = 2'b01,
    VSB_HS_IN       = 2'b10,
    VSB_HS_BOTH     = 2'b11
  } vsb_hs_t;
  typedef enum logic [1:0] {
    VSB_ST_IDLE  = 2'b00,
    VSB_ST_START = 2'b01,
    VSB_ST_DATA  = 2'b10,
    VSB_ST_STOP  = 2'b11
  } vsb_st_t;
  typedef struct packed {
    vsb_hs_t hs;
    logic [`VSB_DIV_W-1:0] div;
  } vsb_cfg_t;
  typedef struct packed {
    logic valid;
    logic [`VSB_DATA_BITS-1:0] data;
  } vsb_byte_t;
endpackage

// file: vsb_bridge.sv
// serial bridge between target uart and usb/socket host streams, with receive fifo
`timescale 1ns/1ns
`include "vsb_params.svh"

module vsb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rd_ptr_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module vsb_bridge
  import vsb_pkg::*;
#(
  parameter int FIFO_DEPTH = `VSB_FIFO_DEPTH,
  parameter int DIV_MAX = `VSB_DIV_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_load_i,
  input wire vsb_pkg::vsb_cfg_t cfg_i,
  output vsb_pkg::vsb_cfg_t cfg_o,
  input wire logic link_en_i,
  input wire logic ser_rx_i,
  output logic ser_tx_o,
  output logic cts_n_o,
  output logic cts_oe_o,
  input wire logic rts_n_i,
  input wire logic sock_conn_i,
  input wire vsb_pkg::vsb_byte_t usb_h2t_i,
  output logic usb_h2t_ready_o,
  input wire vsb_pkg::vsb_byte_t sock_h2t_i,
  output logic sock_h2t_ready_o,
  output vsb_pkg::vsb_byte_t usb_t2h_o,
  input wire logic usb_t2h_ready_i,
  output vsb_pkg::vsb_byte_t sock_t2h_o,
  input wire logic sock_t2h_ready_i
);
  import vsb_pkg::*;
  localparam int DW = `VSB_DATA_BITS;
  localparam int CW = `VSB_DIV_W;

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  vsb_cfg_t cfg_r;
  logic [CW-1:0] div_clamp;
  assign div_clamp = (cfg_i.div < CW'(`VSB_DIV_MIN)) ? CW'(`VSB_DIV_MIN) :
                     (cfg_i.div > CW'(DIV_MAX)) ? CW'(DIV_MAX) : cfg_i.div;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= '{hs: VSB_HS_DISABLED, div: CW'(`VSB_DIV_DEF)};
    end else if (cfg_load_i) begin
      cfg_r <= '{hs: cfg_i.hs, div: div_clamp};
    end
  end
  assign cfg_o = cfg_r;

  wire out_hs = cfg_r.hs[`VSB_HS_OUT_BIT];
  wire in_hs = cfg_r.hs[`VSB_HS_IN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // host stream selection, socket wins
  wire fifo_out_valid;
  wire [DW-1:0] fifo_out_data;
  wire host_t2h_ready = sock_conn_i ? sock_t2h_ready_i : usb_t2h_ready_i;
  vsb_byte_t h2t_sel;
  assign h2t_sel = sock_conn_i ? sock_h2t_i : usb_h2t_i;
  assign sock_t2h_o = '{valid: fifo_out_valid && sock_conn_i, data: fifo_out_data};
  assign usb_t2h_o = '{valid: fifo_out_valid && !sock_conn_i, data: fifo_out_data};

  ////////////////////////////////////////////////////////////////////////////
  // receiver from target
  vsb_st_t rx_st_r;
  vsb_st_t rx_st_nxt;
  logic [CW-1:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [DW-1:0] rx_sh_r;
  logic rx_push_r;
  wire fifo_in_ready;
  // bit counter free-runs while idle; a start edge reloads it to half a bit
  wire rx_tick = (rx_cnt_r == '0);
  wire rx_begin = (rx_st_r == VSB_ST_IDLE) && link_en_i && !ser_rx_i;

  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      VSB_ST_IDLE: if (rx_begin) rx_st_nxt = VSB_ST_START;
      VSB_ST_START: if (rx_tick) rx_st_nxt = ser_rx_i ? VSB_ST_IDLE : VSB_ST_DATA;
      VSB_ST_DATA: if (rx_tick && rx_bit_r == 3'h7) rx_st_nxt = VSB_ST_STOP;
      VSB_ST_STOP: if (rx_tick) rx_st_nxt = VSB_ST_IDLE;
      default: rx_st_nxt = VSB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= VSB_ST_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_push_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_push_r <= (rx_st_r == VSB_ST_STOP) && rx_tick && ser_rx_i;
      if (rx_begin) begin
        rx_cnt_r <= cfg_r.div >> 1;
      end else if (rx_tick) begin
        rx_cnt_r <= cfg_r.div - 1'b1;
      end else begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end
      if (rx_st_r == VSB_ST_DATA && rx_tick) begin
        rx_sh_r <= {ser_rx_i, rx_sh_r[DW-1:1]};
        rx_bit_r <= rx_bit_r + 1'b1;
      end
      if (rx_st_r == VSB_ST_START) begin
        rx_bit_r <= '0;
      end
    end
  end

  // a byte that meets a full fifo is dropped; clear to send is the only guard
  vsb_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push_r),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_sh_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(host_t2h_ready),
    .out_data_o(fifo_out_data)
  );

  // clear to send, active low, driven only with outbound handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_n_o <= 1'b1;
      cts_oe_o <= 1'b0;
    end else begin
      cts_oe_o <= out_hs;
      cts_n_o <= !(out_hs && fifo_in_ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter to target
  vsb_st_t tx_st_r;
  vsb_st_t tx_st_nxt;
  logic [CW-1:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [DW-1:0] tx_sh_r;
  wire tx_tick = (tx_cnt_r == '0);
  wire rts_ok = !in_hs || !rts_n_i;
  wire tx_take = (tx_st_r == VSB_ST_IDLE) && link_en_i && rts_ok;
  wire tx_start = tx_take && h2t_sel.valid;
  assign sock_h2t_ready_o = tx_take && sock_conn_i;
  assign usb_h2t_ready_o = tx_take && !sock_conn_i;

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      VSB_ST_IDLE: if (tx_start) tx_st_nxt = VSB_ST_START;
      VSB_ST_START: if (tx_tick) tx_st_nxt = VSB_ST_DATA;
      VSB_ST_DATA: if (tx_tick && tx_bit_r == 3'h7) tx_st_nxt = VSB_ST_STOP;
      VSB_ST_STOP: if (tx_tick) tx_st_nxt = VSB_ST_IDLE;
      default: tx_st_nxt = VSB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= VSB_ST_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      ser_tx_o <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_start || tx_tick) begin
        tx_cnt_r <= cfg_r.div - 1'b1;
      end else begin
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
      if (tx_start) begin
        tx_sh_r <= h2t_sel.data;
        tx_bit_r <= '0;
        ser_tx_o <= 1'b0;
      end else if (tx_tick) begin
        case (tx_st_r)
          VSB_ST_START: begin
            ser_tx_o <= tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
          end
          VSB_ST_DATA: begin
            ser_tx_o <= (tx_bit_r == 3'h7) ? 1'b1 : tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
            tx_bit_r <= tx_bit_r + 1'b1;
          end
          default: ser_tx_o <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_DEFAULT_CFG: assert property (@(posedge clk_i) rst_i |=>
    cfg_r.hs == VSB_HS_DISABLED && cfg_r.div == CW'(`VSB_DIV_DEF))
    else $error("config not at defaults after reset");
  AST_DIV_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_r.div >= CW'(`VSB_DIV_MIN) && cfg_r.div <= CW'(DIV_MAX))
    else $error("divisor outside legal range");
  AST_CTS_UNDRIVEN: assert property (@(posedge clk_i) disable iff (rst_i)
    !out_hs ##1 !out_hs |-> !cts_oe_o)
    else $error("clear to send driven without outbound handshake");
  AST_CTS_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
    out_hs && !fifo_in_ready |=> cts_n_o && cts_oe_o)
    else $error("clear to send asserted while buffer full");
  AST_RTS_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    in_hs && rts_n_i |-> !tx_start)
    else $error("byte started while target held off");
  AST_FINISH_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st_r == VSB_ST_DATA && !tx_tick |=> tx_st_r == VSB_ST_DATA)
    else $error("byte in flight aborted");
  AST_ENABLE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !link_en_i |-> !tx_start && !rx_begin)
    else $error("traffic while link disabled");
  AST_SOCK_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    sock_conn_i |-> !usb_t2h_o.valid && !usb_h2t_ready_o)
    else $error("usb active during socket session");
  AST_START_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start |=> !ser_tx_o ##1 !ser_tx_o)
    else $error("start bit not low");
  AST_IDLE_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st_r == VSB_ST_IDLE && $past(tx_st_r) == VSB_ST_IDLE |-> ser_tx_o)
    else $error("line not high while idle");
  AST_CTS_ROOM: assert property (@(posedge clk_i) disable iff (rst_i)
    out_hs && fifo_in_ready |=> !cts_n_o && cts_oe_o)
    else $error("clear to send held off while buffer has room");
  AST_RTS_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_hs && link_en_i && tx_st_r == VSB_ST_IDLE |-> usb_h2t_ready_o || sock_h2t_ready_o)
    else $error("host byte refused with inbound handshake off");
  AST_STOP_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st_r == VSB_ST_STOP |-> ser_tx_o)
    else $error("stop bit not high");
endmodule

// file: vsb_target_model.sv
// behavioural target uart with rts/cts for the bridge bench
`timescale 1ns/1ns
module vsb_target_model (
  input wire logic clk_i,
  input wire logic [12:0] div_i,
  input wire logic hold_i,
  input wire logic rx_i,
  input wire logic cts_n_i,
  output logic tx_o,
  output logic rts_n_o,
  output logic [7:0] got_o,
  output int got_cnt_o
);
  initial begin
    tx_o = 1'b1;
    got_cnt_o = 0;
  end
  // rts low while the target can take data
  assign rts_n_o = hold_i;
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    #1;
    while (cts_n_i === 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    tx_o = 1'b0;
    repeat (div_i) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      #1 tx_o = b[k];
      repeat (div_i) @(posedge clk_i);
    end
    #1 tx_o = 1'b1;
    repeat (div_i) @(posedge clk_i);
  endtask
  // always accepts, even after rts is dropped
  always begin
    @(negedge rx_i);
    repeat (div_i / 2) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      repeat (div_i) @(posedge clk_i);
      got_o[k] = rx_i;
    end
    repeat (div_i) @(posedge clk_i);
    got_cnt_o++;
  end
endmodule

// file: vsb_bridge_tb.sv
// self-checking bench for the virtual serial handshake bridge
`timescale 1ns/1ns
`include "vsb_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module vsb_bridge_tb;
  import vsb_pkg::*;
  logic clk_i = 0, rst_i = 1, cfg_load_i = 0, link_en_i = 1, sock_conn_i = 0, hold = 1;
  logic usb_t2h_ready_i = 0, sock_t2h_ready_i = 0, cts_w;
  logic ser_rx_i, ser_tx_o, cts_n_o, cts_oe_o, rts_n_i, usb_h2t_ready_o, sock_h2t_ready_o;
  logic [12:0] bdiv = 13'(`VSB_DIV_DEF);
  logic [7:0] got;
  vsb_cfg_t cfg_i = '0, cfg_o;
  vsb_byte_t usb_h2t_i = '0, sock_h2t_i = '0, usb_t2h_o, sock_t2h_o;
  int got_cnt, rxn = 0, failures = 0, checks = 0;
  // undriven cts: bench pull keeps the target sending
  assign cts_w = cts_oe_o ? cts_n_o : 1'b0;
  vsb_bridge #(.FIFO_DEPTH(32)) dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_load_i(cfg_load_i), .cfg_i(cfg_i),
    .cfg_o(cfg_o), .link_en_i(link_en_i), .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o), .cts_n_o(cts_n_o),
    .cts_oe_o(cts_oe_o), .rts_n_i(rts_n_i), .sock_conn_i(sock_conn_i), .usb_h2t_i(usb_h2t_i),
    .usb_h2t_ready_o(usb_h2t_ready_o), .sock_h2t_i(sock_h2t_i), .sock_h2t_ready_o(sock_h2t_ready_o),
    .usb_t2h_o(usb_t2h_o), .usb_t2h_ready_i(usb_t2h_ready_i), .sock_t2h_o(sock_t2h_o),
    .sock_t2h_ready_i(sock_t2h_ready_i));
  vsb_target_model tgt (.clk_i(clk_i), .div_i(bdiv), .hold_i(hold), .rx_i(ser_tx_o), .cts_n_i(cts_w),
    .tx_o(ser_rx_i), .rts_n_o(rts_n_i), .got_o(got), .got_cnt_o(got_cnt));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cfg(input vsb_hs_t hs, input logic [12:0] d);
    @(posedge clk_i);
    #1 cfg_load_i = 1'b1;
    cfg_i = '{hs: hs, div: d};
    @(posedge clk_i);
    #1 cfg_load_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic h2t(input logic s, input logic [7:0] b);
    int n;
    @(posedge clk_i);
    #1 if (s) sock_h2t_i = '{1'b1, b};
    else usb_h2t_i = '{1'b1, b};
    n = 0;
    // ready looked at settled; the byte is taken at the next edge
    while ((s ? sock_h2t_ready_o : usb_h2t_ready_o) !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    #1 sock_h2t_i = '0;
    usb_h2t_i = '0;
    `CHK("h2t taken", 1'b1, n < 20000)
  endtask
  task automatic wait_rx(input logic [7:0] b);
    int n;
    n = 0;
    rxn++;
    while (got_cnt < rxn && n < 20000) begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK("rx in time", 1'b1, n < 20000)
    `CHK("target rx", b, got)
  endtask
  task automatic t2h(input logic s, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    while ((s ? sock_t2h_o.valid : usb_t2h_o.valid) !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK("t2h in time", 1'b1, n < 20000)
    `CHK("host rx", b, s ? sock_t2h_o.data : usb_t2h_o.data)
    `CHK("other idle", 1'b0, s ? usb_t2h_o.valid : sock_t2h_o.valid)
    if (s) sock_t2h_ready_i = 1'b1;
    else usb_t2h_ready_i = 1'b1;
    @(posedge clk_i);
    #1 sock_t2h_ready_i = 1'b0;
    usb_t2h_ready_i = 1'b0;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    `CHK("tx idle", 1'b1, ser_tx_o)
    `CHK("cts oe", 1'b0, cts_oe_o)
    `CHK("def hs", VSB_HS_DISABLED, cfg_o.hs)
    `CHK("def div", 13'(`VSB_DIV_DEF), cfg_o.div)
    h2t(1'b0, 8'h5a);
    wait_rx(8'h5a);
    tgt.send(8'ha3);
    t2h(1'b0, 8'ha3);
    cfg(VSB_HS_BOTH, 13'h00a);
    `CHK("div low", 13'(`VSB_DIV_MIN), cfg_o.div)
    cfg(VSB_HS_BOTH, 13'h1770);
    `CHK("div high", 13'(`VSB_DIV_MAX), cfg_o.div)
    bdiv = 13'(`VSB_DIV_MIN);
    for (int m = 0; m < 4; m++) begin
      cfg(vsb_hs_t'(m), 13'(`VSB_DIV_MIN));
      `CHK("rdy held", ~m[1], usb_h2t_ready_o)
      `CHK("cts drive", m[0], cts_oe_o)
    end
    `CHK("cts low", 1'b0, cts_n_o)
    hold = 1'b0;
    h2t(1'b0, 8'h81);
    hold = 1'b1;
    wait_rx(8'h81);
    // let the stop bit end so only the held request keeps ready low
    repeat (bdiv) @(posedge clk_i);
    #1 `CHK("paused", 1'b0, usb_h2t_ready_o)
    hold = 1'b0;
    sock_conn_i = 1'b1;
    #1 `CHK("usb muted", 1'b0, usb_h2t_ready_o)
    `CHK("sock ready", 1'b1, sock_h2t_ready_o)
    h2t(1'b1, 8'hc3);
    wait_rx(8'hc3);
    tgt.send(8'h3c);
    t2h(1'b1, 8'h3c);
    sock_conn_i = 1'b0;
    link_en_i = 1'b0;
    #1 `CHK("link off", 1'b0, usb_h2t_ready_o)
    tgt.send(8'h77);
    #1 `CHK("no rx", 1'b0, usb_t2h_o.valid)
    link_en_i = 1'b1;
    cfg(VSB_HS_OUT, 13'(`VSB_DIV_MIN));
    for (int i = 0; i < `VSB_FIFO_DEPTH; i++) tgt.send(8'(i));
    repeat (3) @(posedge clk_i);
    #1 `CHK("cts full", 1'b1, cts_n_o)
    for (int i = 0; i < `VSB_FIFO_DEPTH; i++) t2h(1'b0, 8'(i));
    repeat (3) @(posedge clk_i);
    #1 `CHK("cts free", 1'b0, cts_n_o)
    conclude();
  end
endmodule
